// ---- hw/sram_input_port.sv ----
// Input side of a separate-port double-data-rate burst SRAM.
// Assumes the strobe pair is far slower than mclk so every strobe edge
// is seen by the oversampling; all pins cross via two flip-flops.
`timescale 1ns/1ps
module sram_input_port #(
  parameter int DATA_W = sram_in_pkg::CFG_X36_DATA_W,
  parameter int LANE_W = sram_in_pkg::lane_w_of(DATA_W),
  parameter int LANES = DATA_W / LANE_W,
  parameter int ADDR_W = sram_in_pkg::addr_w_of(DATA_W)
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic strobe_p,
  input wire logic strobe_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [LANES-1:0] byte_lane_mask_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic wr_commit,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data0,
  output logic [DATA_W-1:0] wr_data1,
  output logic [LANES-1:0] wr_lane_en0,
  output logic [LANES-1:0] wr_lane_en1,
  output logic rd_start,
  output logic [ADDR_W-1:0] rd_addr,
  output logic rd_beat,
  output logic rd_beat_idx
);
  import sram_in_pkg::*;

  localparam int PIN_W = 4 + LANES + ADDR_W + DATA_W;

  // ==========================================================
  // Pin synchronisation; strobes travel with the data they qualify
  logic [PIN_W-1:0] pins_raw, pins_s;
  logic sp_s, sn_s, wsel_n_s, rsel_n_s;
  logic [LANES-1:0] mask_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  assign pins_raw = {strobe_p, strobe_n, write_port_select_n,
                     read_port_select_n, byte_lane_mask_n, addr, wr_data_in};

  pin_sync #(
    .W(PIN_W),
    .RST_VAL({2'h0, PIN_IDLE_HI, PIN_IDLE_HI, {(PIN_W-4){1'b0}}})
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(pins_raw),
    .synced(pins_s)
  );

  assign {sp_s, sn_s, wsel_n_s, rsel_n_s, mask_n_s, addr_s, data_s} = pins_s;

  // ==========================================================
  // Strobe rising-edge detection
  logic sp_prev_q, sp_prev_d, sn_prev_q, sn_prev_d;
  logic p_rise, n_rise;

  always_comb begin
    sp_prev_d = sp_s;
    sn_prev_d = sn_s;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sp_prev_q <= 1'b0;
      sn_prev_q <= 1'b0;
    end else begin
      sp_prev_q <= sp_prev_d;
      sn_prev_q <= sn_prev_d;
    end
  end

  assign p_rise = sp_s & ~sp_prev_q;
  assign n_rise = sn_s & ~sn_prev_q;

  // ==========================================================
  // Lane gating of the beat currently on the pins
  logic [DATA_W-1:0] beat_gated;
  logic [LANES-1:0] beat_en;

  lane_gate #(
    .DATA_W(DATA_W),
    .LANE_W(LANE_W),
    .LANES(LANES)
  ) u_gate (
    .data(data_s),
    .mask_n(mask_n_s),
    .data_gated(beat_gated),
    .lane_en(beat_en)
  );

  // ==========================================================
  // Write port
  beat_t wst_q, wst_d;
  logic wr_commit_q, wr_commit_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [DATA_W-1:0] wr_data0_q, wr_data0_d, wr_data1_q, wr_data1_d;
  logic [LANES-1:0] wr_en0_q, wr_en0_d, wr_en1_q, wr_en1_d;

  always_comb begin
    wst_d = wst_q;
    wr_commit_d = PULSE_IDLE;
    wr_addr_d = wr_addr_q;
    wr_data0_d = wr_data0_q;
    wr_data1_d = wr_data1_q;
    wr_en0_d = wr_en0_q;
    wr_en1_d = wr_en1_q;
    case (wst_q)
      BEAT_FIRST: begin
        // Deselected: address, masks and data are all left untouched
        if (p_rise && !wsel_n_s) begin
          wr_addr_d = addr_s;
          wr_data0_d = beat_gated;
          wr_en0_d = beat_en;
          wst_d = BEAT_SECOND;
        end
      end
      BEAT_SECOND: begin
        if (n_rise) begin
          wr_data1_d = beat_gated;
          wr_en1_d = beat_en;
          wr_commit_d = 1'b1;
          wst_d = BEAT_FIRST;
        end else if (p_rise) begin
          // Missing negative edge: drop the burst, honour the new request
          wst_d = wsel_n_s ? BEAT_FIRST : BEAT_SECOND;
          if (!wsel_n_s) begin
            wr_addr_d = addr_s;
            wr_data0_d = beat_gated;
            wr_en0_d = beat_en;
          end
        end
      end
      default: begin
        wst_d = BEAT_FIRST;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wst_q <= BEAT_FIRST;
      wr_commit_q <= PULSE_IDLE;
      wr_addr_q <= '0;
      wr_data0_q <= '0;
      wr_data1_q <= '0;
      wr_en0_q <= '0;
      wr_en1_q <= '0;
    end else begin
      wst_q <= wst_d;
      wr_commit_q <= wr_commit_d;
      wr_addr_q <= wr_addr_d;
      wr_data0_q <= wr_data0_d;
      wr_data1_q <= wr_data1_d;
      wr_en0_q <= wr_en0_d;
      wr_en1_q <= wr_en1_d;
    end
  end

  // ==========================================================
  // Read port, fully separate state so writes never stall it
  beat_t rst_q, rst_d;
  logic rd_start_q, rd_start_d, rd_beat_q, rd_beat_d, rd_idx_q, rd_idx_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;

  always_comb begin
    rst_d = rst_q;
    rd_start_d = PULSE_IDLE;
    rd_beat_d = PULSE_IDLE;
    rd_idx_d = rd_idx_q;
    rd_addr_d = rd_addr_q;
    case (rst_q)
      BEAT_FIRST: begin
        if (p_rise && !rsel_n_s) begin
          rd_addr_d = addr_s;
          rd_start_d = 1'b1;
          rd_beat_d = 1'b1;
          rd_idx_d = 1'b0;
          rst_d = BEAT_SECOND;
        end
      end
      BEAT_SECOND: begin
        // A started read always completes its second transfer
        if (n_rise || p_rise) begin
          rd_beat_d = 1'b1;
          rd_idx_d = 1'b1;
          rst_d = BEAT_FIRST;
        end
      end
      default: begin
        rst_d = BEAT_FIRST;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rst_q <= BEAT_FIRST;
      rd_start_q <= PULSE_IDLE;
      rd_beat_q <= PULSE_IDLE;
      rd_idx_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rst_q <= rst_d;
      rd_start_q <= rd_start_d;
      rd_beat_q <= rd_beat_d;
      rd_idx_q <= rd_idx_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  assign wr_commit = wr_commit_q;
  assign wr_addr = wr_addr_q;
  assign wr_data0 = wr_data0_q;
  assign wr_data1 = wr_data1_q;
  assign wr_lane_en0 = wr_en0_q;
  assign wr_lane_en1 = wr_en1_q;
  assign rd_start = rd_start_q;
  assign rd_addr = rd_addr_q;
  assign rd_beat = rd_beat_q;
  assign rd_beat_idx = rd_idx_q;
endmodule

// ---- include/sram_in_pkg.sv ----
// Constants for the synchronous input side of a two-port burst SRAM.
// Assumes a single fast system clock that oversamples the strobe pins.
package sram_in_pkg;

  // ==========================================================
  // Configurations: data width, lane width, address width
  localparam int CFG_X8_DATA_W = 8;
  localparam int CFG_X18_DATA_W = 18;
  localparam int CFG_X36_DATA_W = 36;
  localparam int NIBBLE_LANE_W = 4;
  localparam int BYTE_LANE_W = 9;
  localparam int CFG_X8_ADDR_W = 20;
  localparam int CFG_X18_ADDR_W = 19;
  localparam int CFG_X36_ADDR_W = 18;

  // ==========================================================
  // Timing
  localparam int SYNC_STAGES = 2;
  localparam int BEATS_PER_BURST = 2;

  // ==========================================================
  // Reset values
  localparam logic PIN_IDLE_HI = 1'h1;
  localparam logic PULSE_IDLE = 1'h0;

  typedef enum logic [0:0] {
    BEAT_FIRST,
    BEAT_SECOND
  } beat_t;

  function automatic int lane_w_of(input int dw);
    return (dw == CFG_X8_DATA_W) ? NIBBLE_LANE_W : BYTE_LANE_W;
  endfunction

  function automatic int addr_w_of(input int dw);
    if (dw == CFG_X8_DATA_W) begin
      return CFG_X8_ADDR_W;
    end
    if (dw == CFG_X18_DATA_W) begin
      return CFG_X18_ADDR_W;
    end
    return CFG_X36_ADDR_W;
  endfunction

endpackage

// ---- hw/pin_sync.sv ----
// Two-flop synchroniser for a bundle of pins.
// Assumes pins change slowly against mclk; the first stage feeds only
// the second.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] synced
);
  import sram_in_pkg::*;

  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] stab_q, stab_d;

  always_comb begin
    meta_d = pin;
    stab_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      stab_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign synced = stab_q;
endmodule

// ---- hw/lane_gate.sv ----
// Per-lane gating of one write beat by its active-low lane masks.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module lane_gate #(
  parameter int DATA_W = 36,
  parameter int LANE_W = 9,
  parameter int LANES = 4
) (
  input wire logic [DATA_W-1:0] data,
  input wire logic [LANES-1:0] mask_n,
  output logic [DATA_W-1:0] data_gated,
  output logic [LANES-1:0] lane_en
);
  import sram_in_pkg::*;

  // ==========================================================
  // Lane i covers bits [i*LANE_W +: LANE_W]
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    // Masked lanes are zeroed so nothing downstream can store them
    assign lane_en[i] = ~mask_n[i];
    assign data_gated[i*LANE_W +: LANE_W] =
      mask_n[i] ? '0 : data[i*LANE_W +: LANE_W];
  end
endmodule

// ---- tb/sram_in_props.sv ----
// Assertions on the input port's request outputs.
// Assumes pins hold steady three clocks around each strobe rise.
`timescale 1ns/1ps
module sram_in_checker #(
  parameter int LANES = 4,
  parameter int ADDR_W = 18
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic strobe_p,
  input wire logic strobe_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [LANES-1:0] byte_lane_mask_n,
  input wire logic wr_commit,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES-1:0] wr_lane_en1,
  input wire logic rd_start,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic rd_beat,
  input wire logic rd_beat_idx
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ==========
  // Write port
  chk_commit_once: assert property (wr_commit |=> !wr_commit)
    else $error("commit too long");
  chk_commit_n: assert property (wr_commit |->
    $past(strobe_n, 2) && !$past(strobe_n, 5)) else $error("commit off");
  chk_mask_beat: assert property (wr_commit |->
    wr_lane_en1 == ~$past(byte_lane_mask_n, 2)) else $error("bad enables");
  chk_write_go: assert property ($rose(strobe_p) &&
    !write_port_select_n |-> ##[2:30] wr_commit) else $error("no commit");
  chk_waddr_hold: assert property ($changed(wr_addr) |->
    $past(strobe_p, 2) && !$past(write_port_select_n, 2))
    else $error("write address moved");
  // ==========
  // Read port
  chk_rd_first: assert property (
    rd_start |-> rd_beat && !rd_beat_idx) else $error("bad first beat");
  chk_rd_second: assert property (rd_start |->
    ##[1:30] (rd_beat && rd_beat_idx)) else $error("no second beat");
  chk_raddr_hold: assert property ($changed(rd_addr) |->
    $past(strobe_p, 2) && !$past(read_port_select_n, 2))
    else $error("read address moved");
  chk_both_go: assert property ($rose(strobe_p) &&
    !read_port_select_n && !write_port_select_n |-> ##[2:3] rd_start)
    else $error("read blocked");
endmodule
bind sram_input_port sram_in_checker #(.LANES(LANES), .ADDR_W(ADDR_W))
  u_chk (.*);

// ---- tb/sram_ctrl_model.sv ----
// Memory controller model driving strobes, selects, address and data.
// Assumes one caller at a time; each phase lasts gap clocks.
`timescale 1ns/1ps
module sram_ctrl_model #(
  parameter int DW = 36,
  parameter int LN = 4,
  parameter int AW = 18
) (
  input wire logic mclk,
  output logic strobe_p,
  output logic strobe_n,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [LN-1:0] byte_lane_mask_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wr_data_in
);
  initial begin
    {strobe_p, strobe_n, write_port_select_n, read_port_select_n} = 4'h3;
    {byte_lane_mask_n, addr, wr_data_in} = '0;
  end
  // A gap of three keeps pins steady around each strobe rise
  task automatic burst(input logic w_n, r_n, input logic [AW-1:0] a,
      input logic [DW-1:0] d0, d1, input logic [LN-1:0] m0, m1,
      input int gap);
    @(posedge mclk);
    {write_port_select_n, read_port_select_n} <= {w_n, r_n};
    {addr, wr_data_in, byte_lane_mask_n} <= {a, d0, m0};
    repeat (gap) @(posedge mclk);
    strobe_p <= 1'b1;
    repeat (gap) @(posedge mclk);
    // Released pins go inverted so a stale value cannot pass
    {write_port_select_n, read_port_select_n} <= 2'h3;
    {addr, wr_data_in, byte_lane_mask_n} <= {~a, d1, m1};
    repeat (gap) @(posedge mclk);
    {strobe_p, strobe_n} <= 2'h1;
    repeat (gap) @(posedge mclk);
    {wr_data_in, byte_lane_mask_n} <= {~d1, ~m1};
    repeat (gap) @(posedge mclk);
    strobe_n <= 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the 36-bit input port and controller model.
// Assumes the design package and the model are compiled first.
`timescale 1ns/1ps
`define check_eq(n, e, s) begin \
  samples_checked++; \
  if ((e) !== (s)) begin \
    failures++; \
    $display("BAD %s expected %h seen %h", n, e, s); \
  end \
end
module testbench;
  import sram_in_pkg::*;
  localparam int DW = CFG_X36_DATA_W;
  localparam int LW = BYTE_LANE_W;
  localparam int LN = DW / LW;
  localparam int AW = CFG_X36_ADDR_W;
  localparam int WW = AW + 2 * DW + 2 * LN;
  logic [WW-1:0] wq[$];
  logic [AW:0] rq[$];
  logic [WW-1:0] w;
  logic [AW:0] r;
  int failures = 0;
  int samples_checked = 0;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic strobe_p, strobe_n, write_port_select_n, read_port_select_n;
  logic wr_commit, rd_start, rd_beat, rd_beat_idx, wn, rn;
  logic [LN-1:0] byte_lane_mask_n, wr_lane_en0, wr_lane_en1, m0, m1;
  logic [AW-1:0] addr, wr_addr, rd_addr;
  logic [DW-1:0] wr_data_in, wr_data0, wr_data1;

  always #50 mclk = ~mclk;
  sram_ctrl_model #(.DW(DW), .LN(LN), .AW(AW)) u_ctrl (.*);
  sram_input_port #(.DATA_W(DW)) DUT (.*);

  // ==========
  // Expectations
  function automatic logic [DW-1:0] gate(input logic [DW-1:0] d,
      input logic [LN-1:0] m);
    gate = d;
    for (int i = 0; i < LN; i++) if (m[i]) gate[i*LW +: LW] = '0;
  endfunction
  task automatic go(input logic w_n, r_n, input logic [AW-1:0] a,
      input logic [DW-1:0] d0, d1, input logic [LN-1:0] k0, k1,
      input int gap);
    if (!w_n) wq.push_back({a, gate(d0, k0), gate(d1, k1), ~k0, ~k1});
    if (!r_n) rq.push_back({1'b0, a});
    if (!r_n) rq.push_back({1'b1, a});
    u_ctrl.burst(w_n, r_n, a, d0, d1, k0, k1, gap);
  endtask
  // ==========
  // Monitor, sampling at the falling edge once outputs have settled
  always @(negedge mclk) begin
    if (wr_commit) begin
      // An unexpected commit compares against unknowns and fails
      if (wq.size() == 0) wq.push_back('x);
      w = wq.pop_front();
      `check_eq("write", w, {wr_addr, wr_data0, wr_data1, wr_lane_en0, wr_lane_en1})
    end
    if (rd_beat) begin
      if (rq.size() == 0) rq.push_back('x);
      r = rq.pop_front();
      `check_eq("read", r, {rd_beat_idx, rd_addr})
    end
  end
  // ==========
  // Closing
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hbb3e_57a8));
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    // First four cover every select pair with all-on and all-off masks
    for (int i = 0; i < 16; i++) begin
      wn = (i < 4) ? i[0] : 1'($urandom());
      rn = (i < 4) ? i[1] : 1'($urandom());
      m0 = (i < 4) ? {LN{i[1]}} : LN'($urandom());
      m1 = (i < 4) ? {LN{i[0]}} : LN'($urandom());
      go(wn, rn, AW'($urandom()), DW'({$urandom(), $urandom()}),
        DW'({$urandom(), $urandom()}), m0, m1, 3 + (i % 3));
    end
    repeat (10) @(posedge mclk);
    `check_eq("pending", 0, wq.size() + rq.size())
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule
